//--- design/quad_decoder.sv
// Purpose: Quadrature decoder for one incremental encoder
// Assumes: Channels are asynchronous push-pull levels
// Notes: Forward when channel A leads channel B by a quarter period
`default_nettype none
module quad_decoder import sso_pkg::*; (
	input wire logic clock,
	input wire logic resetn,
	input wire logic ch_a,
	input wire logic ch_b,
	output logic fwd,
	output logic back,
	output logic dir,
	output logic signed [POS_W-1:0] pos
);
	// Two-stage synchronisers, first stage read only by second
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	// Previous synchronised phase pair
	logic [1:0] prev_q;
	logic signed [1:0] delta;

	// Phase step: +1 forward, -1 backward, 0 idle or skipped
	function automatic logic signed [1:0] quad_step(
		input logic [1:0] p, input logic [1:0] c);
		case ({p, c})
			4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'sb01;
			4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'sb11;
			default: quad_step = 2'sb00;
		endcase
	endfunction

	// Direction from the phase order of the two channels
	assign delta = quad_step(prev_q, sync_q);

	// Synchronise both channels
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 2'h0;
			sync_q <= 2'h0;
		end else begin
			meta_q <= {ch_a, ch_b};
			sync_q <= meta_q;
		end
	end

	// Count edges; 100 kHz pulses leave hundreds of clocks per edge
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev_q <= 2'h0;
			fwd <= 1'b0;
			back <= 1'b0;
			dir <= 1'b0;
			pos <= '0;
		end else begin
			prev_q <= sync_q;
			fwd <= (delta == 2'sb01);
			back <= (delta == 2'sb11);
			if (delta != 2'sb00) begin
				dir <= (delta == 2'sb01);
			end
			pos <= pos + POS_W'(delta);
		end
	end

	// A decoded forward step always moves the count up by one
	step_count_a: assert property (@(posedge clock) disable iff (!resetn)
		fwd |-> pos == $past(pos) + 1)
		else $error("encoder count missed a forward step");
endmodule
`default_nettype wire

//--- design/safety_output_restart_interlock.sv
// Purpose: Safety switching outputs with restart interlock, contactor
//   feedback check, universal pins and dual encoder standstill
// Assumes: Field and error inputs come from logic on the same clock
// Notes: Registers sit on a plain port, read data one cycle later
`default_nettype none
module safety_output_restart_interlock import sso_pkg::*; #(
	parameter int FB_TIMEOUT = FB_TIMEOUT_CYC,
	parameter int SPEED_WIN = SPEED_WIN_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata,
	input wire logic bus_we,
	input wire logic bus_re,
	output logic [DATA_W-1:0] bus_rdata,
	input wire logic [NUM_SSO-1:0] field_occupied,
	input wire logic device_error,
	input wire logic contamination,
	input wire logic [1:0] enc_a,
	input wire logic [1:0] enc_b,
	input wire logic [NUM_UIO-1:0] uio_in,
	output logic [NUM_UIO-1:0] uio_out,
	output logic [NUM_UIO-1:0] uio_oe,
	output logic [NUM_SSO-1:0] safety_switch_output,
	output logic [CASE_W-1:0] monitoring_case,
	output logic standstill
);
	// Software registers
	logic [CTRL_W-1:0] ctrl_q;
	logic [NUM_UIO-1:0] dir_q;
	logic [7:0] func_q;
	logic [DATA_W-1:0] fb_time_q;
	logic [7:0] case_q;
	// Universal pin synchronisers
	logic [NUM_UIO-1:0] uio_meta_q;
	logic [NUM_UIO-1:0] uio_s_q;
	// Interlock, feedback and pushbutton state
	logic [NUM_SSO-1:0] lock_q, lock_d, sso_d;
	logic press_prev_q;
	logic fb_err_q, fb_err_d;
	logic [DATA_W-1:0] fb_tmr_q;
	logic stat_val_q, stat_err_q;
	// Encoder outputs and speed measurement
	logic [1:0] enc_fwd, enc_back, enc_dir;
	logic signed [POS_W-1:0] enc_pos [2];
	logic signed [POS_W-1:0] cnt_q [2];
	logic [POS_W-1:0] speed_q [2];
	logic [DATA_W-1:0] win_q;
	logic [NUM_UIO-1:0] uio_out_d, out_m;
	logic [DATA_W-1:0] rd_mux;

	// Pins whose function field equals a code
	function automatic logic [NUM_UIO-1:0] fn_mask(
		input logic [7:0] f, input logic [1:0] code);
		fn_mask = '0;
		for (int i = 0; i < NUM_UIO; i++) begin
			fn_mask[i] = (f[2*i +: 2] == code);
		end
	endfunction

	// Magnitude of a signed step count
	function automatic logic [POS_W-1:0] mag(
		input logic signed [POS_W-1:0] v);
		mag = (v < 0) ? POS_W'(-v) : POS_W'(v);
	endfunction

	// Named decodes
	wire [NUM_SSO-1:0] ril_en = ctrl_q[CTRL_RIL_LSB +: NUM_SSO];
	wire fb_en = ctrl_q[CTRL_FB_EN];
	wire pair_out = ctrl_q[CTRL_PAIR_OUT];
	wire pair_in = ctrl_q[CTRL_PAIR_IN];
	wire wr_ctrl = bus_we && (bus_addr == OFF_CTRL);
	wire wr_dir = bus_we && (bus_addr == OFF_UIO_DIR);
	wire wr_func = bus_we && (bus_addr == OFF_UIO_FUNC);
	wire wr_fbt = bus_we && (bus_addr == OFF_FB_TIME);
	wire wr_case = bus_we && (bus_addr == OFF_CASE);
	wire wr_stat = bus_we && (bus_addr == OFF_STATUS);

	// Pins taken by pairs leave the general pool
	wire [NUM_UIO-1:0] pair_m = {{2{pair_in}}, {2{pair_out}}};
	assign out_m = (dir_q | {2'b00, {2{pair_out}}}) & ~{{2{pair_in}}, 2'b00};
	wire [NUM_UIO-1:0] in_m = ~dir_q & ~pair_m;
	wire [NUM_UIO-1:0] in_act = in_m & uio_s_q;
	// Input functions; restart also acknowledges the interlock
	wire press_lvl = |(in_act & (fn_mask(func_q, FN_RESET) |
		fn_mask(func_q, FN_RESTART)));
	wire fb_lvl = |(in_act & fn_mask(func_q, FN_FEEDBACK));
	wire sleep_lvl = |(in_act & fn_mask(func_q, FN_SLEEP));
	wire rst_press = press_lvl && !press_prev_q;

	// Interlock and output decision per output
	assign lock_d = ril_en & (field_occupied |
		(lock_q & ~({NUM_SSO{rst_press}} & ~field_occupied)));
	assign sso_d = ~field_occupied & ~(ril_en & lock_q) &
		{NUM_SSO{!device_error && !fb_err_d && !sleep_lvl}};

	// Feedback: contact closed (high) means contactor dropped out
	wire fb_expect = !(|safety_switch_output);
	wire fb_change = (|sso_d) != (|safety_switch_output);
	wire fb_late = fb_en && (fb_tmr_q == '0) && (fb_lvl != fb_expect);
	assign fb_err_d = fb_late ||
		(fb_err_q && !(wr_stat && bus_wdata[ST_FB_ERR]));

	// Status signal per pin in output mode; pair mirrors output 0
	genvar g;
	generate
		for (g = 0; g < NUM_UIO; g++) begin : g_pin
			wire [1:0] code = func_q[2*g +: 2];
			wire sel = (code == OF_RESET_REQ) ? |(ril_en & lock_q) :
				(code == OF_CONTAM) ? contamination :
				(code == OF_STILL) ? standstill : fb_err_q;
			if (g < 2) begin : g_pair
				assign uio_out_d[g] = pair_out ? sso_d[0] : sel;
			end else begin : g_plain
				assign uio_out_d[g] = sel;
			end
		end
	endgenerate

	// Complementary static input on pins 2 and 3
	wire stat_err_d = pair_in && (uio_s_q[2] == uio_s_q[3]);
	wire stat_val_d = pair_in && !uio_s_q[2] && uio_s_q[3];

	// Window end and standstill case choice
	wire win_end = (win_q == '0);
	wire still_now = (speed_q[0] == '0) && (speed_q[1] == '0);
	wire [CASE_W-1:0] case_d = still_now ?
		case_q[CASE_STILL_LSB +: CASE_W] :
		case_q[CASE_MOVE_LSB +: CASE_W];

	// Read decode, unmapped offsets read zero
	wire [DATA_W-1:0] status_w = DATA_W'({monitoring_case, 1'b0,
		sleep_lvl, stat_err_q, stat_val_q, enc_dir, standstill,
		fb_err_q, ril_en & lock_q, safety_switch_output});
	assign rd_mux =
		(bus_addr == OFF_CTRL) ? DATA_W'(ctrl_q) :
		(bus_addr == OFF_UIO_DIR) ? DATA_W'(dir_q) :
		(bus_addr == OFF_UIO_FUNC) ? DATA_W'(func_q) :
		(bus_addr == OFF_FB_TIME) ? fb_time_q :
		(bus_addr == OFF_CASE) ? DATA_W'(case_q) :
		(bus_addr == OFF_STATUS) ? status_w :
		(bus_addr == OFF_POS0) ? DATA_W'(enc_pos[0]) :
		(bus_addr == OFF_POS1) ? DATA_W'(enc_pos[1]) :
		(bus_addr == OFF_SPEED) ? {speed_q[1], speed_q[0]} : '0;

	// One decoder per encoder; each encoder owns one input pair
	for (g = 0; g < 2; g++) begin : g_enc
		quad_decoder u_dec (
			.clock(clock),
			.resetn(resetn),
			.ch_a(enc_a[g]),
			.ch_b(enc_b[g]),
			.fwd(enc_fwd[g]),
			.back(enc_back[g]),
			.dir(enc_dir[g]),
			.pos(enc_pos[g])
		);
	end

	// Software writes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= CTRL_RST;
			dir_q <= DIR_RST;
			func_q <= FUNC_RST;
			fb_time_q <= DATA_W'(FB_TIMEOUT);
			case_q <= CASE_RST;
		end else begin
			if (wr_ctrl) ctrl_q <= bus_wdata[CTRL_W-1:0];
			if (wr_dir) dir_q <= bus_wdata[NUM_UIO-1:0];
			if (wr_func) func_q <= bus_wdata[7:0];
			if (wr_fbt) fb_time_q <= bus_wdata;
			if (wr_case) case_q <= bus_wdata[7:0];
		end
	end

	// Read data for exactly the cycle after the strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) bus_rdata <= '0;
		else bus_rdata <= bus_re ? rd_mux : '0;
	end

	// Pin synchronisers, pushbutton edge; interlocks set after reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			uio_meta_q <= '0;
			uio_s_q <= '0;
			press_prev_q <= 1'b0;
			lock_q <= '1;
		end else begin
			uio_meta_q <= uio_in;
			uio_s_q <= uio_meta_q;
			press_prev_q <= press_lvl;
			lock_q <= lock_d;
		end
	end

	// Outputs and pin drive, all from flip-flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			safety_switch_output <= '0;
			uio_out <= '0;
			uio_oe <= '0;
			stat_val_q <= 1'b0;
			stat_err_q <= 1'b0;
		end else begin
			safety_switch_output <= sso_d;
			uio_out <= uio_out_d & out_m;
			uio_oe <= out_m;
			stat_val_q <= stat_val_d;
			stat_err_q <= stat_err_d;
		end
	end

	// Feedback timer restarts when the outputs go from all off to any on, or back
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fb_tmr_q <= DATA_W'(FB_TIMEOUT);
			fb_err_q <= 1'b0;
		end else begin
			if (fb_change) fb_tmr_q <= fb_time_q;
			else if (fb_tmr_q != '0) fb_tmr_q <= fb_tmr_q - 1'b1;
			fb_err_q <= fb_err_d;
		end
	end

	// Per-window step counts; zero in both means standstill
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			win_q <= DATA_W'(SPEED_WIN - 1);
			cnt_q <= '{default: '0};
			speed_q <= '{default: '0};
			standstill <= 1'b1;
			monitoring_case <= '0;
		end else begin
			win_q <= win_end ? DATA_W'(SPEED_WIN - 1) : win_q - 1'b1;
			for (int i = 0; i < 2; i++) begin
				if (win_end) begin
					speed_q[i] <= mag(cnt_q[i]);
					cnt_q[i] <= '0;
				end else if (enc_fwd[i]) cnt_q[i] <= cnt_q[i] + 1'b1;
				else if (enc_back[i]) cnt_q[i] <= cnt_q[i] - 1'b1;
			end
			standstill <= still_now;
			monitoring_case <= case_d;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// Steps of a successful reset
	sequence reset_taken;
		ril_en[0] && lock_q[0] && rst_press && !field_occupied[0];
	endsequence
	sequence quiet;
		!field_occupied[0] && !device_error && !fb_err_d && !sleep_lvl;
	endsequence

	field_off_a: assert property (
		field_occupied[0] |=> !safety_switch_output[0])
		else $error("output on with field occupied");
	stay_off_a: assert property (
		ril_en[0] && lock_q[0] && !rst_press |=> !safety_switch_output[0])
		else $error("interlocked output came on without reset");
	reset_on_a: assert property (
		(reset_taken and quiet) ##1 (quiet and ril_en[0]) |=>
		safety_switch_output[0])
		else $error("reset press did not restore output");
	reset_ignored_a: assert property (
		ril_en[0] && rst_press && field_occupied[0] |=>
		lock_q[0] && !safety_switch_output[0])
		else $error("reset accepted with field occupied");
	ril_disabled_a: assert property (
		!ril_en[1] |=> !lock_q[1])
		else $error("disabled interlock still latched");
	still_case_a: assert property (
		still_now |=> standstill &&
		monitoring_case == $past(case_q[CASE_STILL_LSB +: CASE_W]))
		else $error("standstill case not selected");
	fb_late_a: assert property (
		fb_late |=> fb_err_q && safety_switch_output == '0)
		else $error("late feedback not flagged");
	pair_out_a: assert property (
		pair_out && !$past(dir_q[0]) ##1 pair_out |->
		uio_oe[1:0] == 2'b11 && uio_out[0] == uio_out[1])
		else $error("output pair channels differ");
	static_err_a: assert property (
		pair_in && uio_s_q[2] == uio_s_q[3] |=> stat_err_q && !stat_val_q)
		else $error("static input error missed");
endmodule
`default_nettype wire

//--- inc/sso_pkg.sv
// Purpose: Shared constants for the safety output and encoder block
// Assumes: 100 MHz clock, 32-bit register port with byte offsets
// Notes: Register offsets, fields, reset values and timing counts
`default_nettype none
package sso_pkg;
	// Clock period in nanoseconds
	localparam int CLK_PERIOD_NS = 10;
	// Contactor feedback settle time, microseconds
	localparam int FB_TIMEOUT_US = 100;
	// Longest wait, so rounded down to whole cycles
	localparam int FB_TIMEOUT_CYC = (FB_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	// Speed measuring window, microseconds
	localparam int SPEED_WIN_US = 1000;
	localparam int SPEED_WIN_CYC = (SPEED_WIN_US * 1000) / CLK_PERIOD_NS;
	// Widths and counts
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_SSO = 2;
	localparam int NUM_UIO = 4;
	localparam int POS_W = 16;
	localparam int CASE_W = 4;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_UIO_DIR = 8'h04;
	localparam logic [7:0] OFF_UIO_FUNC = 8'h08;
	localparam logic [7:0] OFF_FB_TIME = 8'h0C;
	localparam logic [7:0] OFF_CASE = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_POS0 = 8'h18;
	localparam logic [7:0] OFF_POS1 = 8'h1C;
	localparam logic [7:0] OFF_SPEED = 8'h20;
	// Control register fields
	localparam int CTRL_RIL_LSB = 0;
	localparam int CTRL_FB_EN = 2;
	localparam int CTRL_PAIR_OUT = 3;
	localparam int CTRL_PAIR_IN = 4;
	localparam int CTRL_W = 5;
	// Case register fields
	localparam int CASE_STILL_LSB = 0;
	localparam int CASE_MOVE_LSB = 4;
	// Status register fields
	localparam int ST_SSO_LSB = 0;
	localparam int ST_LOCK_LSB = 2;
	localparam int ST_FB_ERR = 4;
	localparam int ST_STILL = 5;
	localparam int ST_DIR_LSB = 6;
	localparam int ST_STAT_VAL = 8;
	localparam int ST_STAT_ERR = 9;
	localparam int ST_SLEEP = 10;
	localparam int ST_CASE_LSB = 12;
	// Reset values: both interlocks on, all pins inputs
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h03;
	localparam logic [NUM_UIO-1:0] DIR_RST = 4'h0;
	localparam logic [7:0] FUNC_RST = 8'h00;
	localparam logic [7:0] CASE_RST = 8'h00;
	// Function of a pin set as input
	typedef enum logic [1:0] {
		FN_RESET = 2'h0,
		FN_FEEDBACK = 2'h1,
		FN_SLEEP = 2'h2,
		FN_RESTART = 2'h3
	} uio_in_fn_t;
	// Status signal shown on a pin set as output
	typedef enum logic [1:0] {
		OF_RESET_REQ = 2'h0,
		OF_CONTAM = 2'h1,
		OF_STILL = 2'h2,
		OF_FB_ERR = 2'h3
	} uio_out_fn_t;
endpackage
`default_nettype wire

//--- verification/enc_contactor_model.sv
// Purpose: Two quadrature encoders and the contactor auxiliary contacts
// Assumes: One clock; encoder steps spaced STEP cycles apart
// Notes: Feedback high means all contactors released
`default_nettype none
module enc_contactor_model #(
	parameter int STEP = 250
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic start,
	input wire logic [7:0] n0,
	input wire logic [7:0] n1,
	input wire logic [1:0] rev,
	input wire logic [1:0] sso,
	input wire logic stuck_open,
	output logic [1:0] enc_a,
	output logic [1:0] enc_b,
	output logic fb,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// Steps still owed and phase, kept apart per encoder
	logic [7:0] left_q [2];
	logic [1:0] ph_q [2];
	// Quarter period spacing; 250 cycles keeps pulses at 100 kHz or less
	int tick_q;
	// Contact release delay line
	logic [2:0] off_q;
	// Step generator, forward counts phase up
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			left_q <= '{8'h00, 8'h00};
			ph_q <= '{2'h0, 2'h0};
			tick_q <= 0;
		end else if (start) begin
			left_q <= '{n0, n1};
			tick_q <= 0;
		end else if (tick_q == STEP - 1) begin
			tick_q <= 0;
			for (int i = 0; i < 2; i++) begin
				if (left_q[i] != 8'h00) begin
					// Each step is a hundredth of a centimetre or finer
					left_q[i] <= left_q[i] - 8'h01;
					ph_q[i] <= rev[i] ? ph_q[i] - 2'h1 : ph_q[i] + 2'h1;
				end
			end
		end else begin
			tick_q <= tick_q + 1;
		end
	end
	assign busy = (left_q[0] != 8'h00) || (left_q[1] != 8'h00);
	// Push-pull levels, A a quarter period ahead of B going forward
	assign enc_a = {^ph_q[1], ^ph_q[0]};
	assign enc_b = {ph_q[1][1], ph_q[0][1]};
	// Contacts follow a few cycles late; a stuck one never pulls in
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			off_q <= 3'h7;
		end else begin
			off_q <= {off_q[1:0], sso == 2'b00};
		end
	end
	assign fb = stuck_open | off_q[2];
endmodule
`default_nettype wire

//--- verification/safety_output_restart_interlock_bench.sv
// Purpose: Self-checking bench for the safety output block
// Assumes: Short feedback timeout and speed window parameters
// Notes: Pin 0 reset button, pin 1 contactor feedback, pin 3 status
`default_nettype none
module safety_output_restart_interlock_bench import sso_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FBT = 20;
	localparam int SW = 600;
	localparam int STEP = 250;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0000_0000;
	logic bus_we = 1'b0;
	logic bus_re = 1'b0;
	logic [31:0] bus_rdata;
	logic [1:0] field_occupied = 2'b00;
	logic device_error = 1'b0;
	logic contamination = 1'b0;
	logic [3:0] drv = 4'h0; // Levels driven at undriven pins
	logic [3:0] uio_in, uio_out, uio_oe;
	logic [1:0] sso, enc_a, enc_b;
	logic [1:0] rev = 2'b10;
	logic [CASE_W-1:0] mcase;
	logic standstill, fb, busy;
	logic start = 1'b0;
	logic stuck = 1'b0;
	// Contacts reach pin 1 only once it is a feedback input, else false press
	logic fb_wired = 1'b0;
	logic [7:0] n0 = 8'h00;
	logic [7:0] n1 = 8'h00;
	logic [7:0] cs;
	logic [31:0] rd_q;
	logic [31:0] lfsr_q = 32'h3727_d8aa;
	int failures = 0;
	int n_compared = 0;
	// Free-running 100 MHz clock
	always #5 clock = ~clock;
	// Pin level: driven by the block where enabled, else by the far side
	assign uio_in = (uio_oe & uio_out) |
		(~uio_oe & {drv[3:2], fb & fb_wired, drv[0]});
	safety_output_restart_interlock #(.FB_TIMEOUT(FBT), .SPEED_WIN(SW)) u_dut (
		.clock(clock), .resetn(resetn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
		.bus_rdata(bus_rdata), .field_occupied(field_occupied),
		.device_error(device_error), .contamination(contamination),
		.enc_a(enc_a), .enc_b(enc_b), .uio_in(uio_in), .uio_out(uio_out),
		.uio_oe(uio_oe), .safety_switch_output(sso),
		.monitoring_case(mcase), .standstill(standstill));
	enc_contactor_model #(.STEP(STEP)) u_far (
		.clock(clock), .resetn(resetn), .start(start), .n0(n0), .n1(n1),
		.rev(rev), .sso(sso), .stuck_open(stuck), .enc_a(enc_a),
		.enc_b(enc_b), .fb(fb), .busy(busy));
	// Next pseudo-random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic finish_test();
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (e !== g) begin
			failures++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= d;
		bus_we <= 1'b1;
		@(posedge clock);
		bus_we <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		bus_addr <= a;
		bus_re <= 1'b1;
		@(posedge clock);
		bus_re <= 1'b0;
		#1;
		rd_q = bus_rdata;
	endtask
	task automatic rdchk(input string what, input logic [7:0] a,
		input logic [31:0] e);
		rd(a);
		chk(what, e, rd_q);
	endtask
	// Field and error levels; outputs looked at one edge later
	task automatic setf(input logic [1:0] f, input logic e);
		@(posedge clock);
		field_occupied <= f;
		device_error <= e;
		cyc(1);
	endtask
	// Button held long enough to pass the input synchroniser
	task automatic press();
		@(posedge clock);
		drv[0] <= 1'b1;
		repeat (5) @(posedge clock);
		drv[0] <= 1'b0;
		cyc(2);
	endtask
	task automatic wait_sso(input logic [1:0] v, input int bound);
		for (int i = 0; i < bound && sso !== v; i++)
			cyc(1);
		if (sso !== v) begin
			failures++;
			$display("Error sso wait expected %h seen %h", v, sso);
			finish_test();
		end
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		cyc(1);
		chk("sso", 32'h0, 32'(sso));
		chk("still", 32'h1, 32'(standstill));
		rdchk("ctrl", OFF_CTRL, 32'(CTRL_RST));
		rdchk("dir", OFF_UIO_DIR, 32'h0);
		rdchk("func", OFF_UIO_FUNC, 32'h0);
		rdchk("fbtime", OFF_FB_TIME, 32'(FBT));
		rdchk("unmapped", 8'h30, 32'h0);
		wr(OFF_UIO_DIR, 32'h8);
		wr(OFF_UIO_FUNC, 32'h4);
		@(posedge clock);
		fb_wired <= 1'b1;
		rdchk("func", OFF_UIO_FUNC, 32'h4);
		chk("oe", 32'h8, 32'(uio_oe));
		chk("reset req", 32'h1, 32'(uio_out[3]));
		press();
		chk("sso", 32'h3, 32'(sso));
		chk("reset req", 32'h0, 32'(uio_out[3]));
		$display("Test defaults done");
		setf(2'b01, 1'b0);
		chk("sso", 32'h2, 32'(sso));
		setf(2'b00, 1'b0);
		cyc(10);
		chk("sso", 32'h2, 32'(sso));
		rd(OFF_STATUS);
		chk("lock", 32'h6, 32'(rd_q[3:0]));
		setf(2'b01, 1'b0);
		press();
		setf(2'b00, 1'b0);
		cyc(10);
		chk("sso", 32'h2, 32'(sso));
		press();
		chk("sso", 32'h3, 32'(sso));
		wr(OFF_CTRL, 32'h1);
		setf(2'b10, 1'b0);
		chk("sso", 32'h1, 32'(sso));
		setf(2'b00, 1'b0);
		chk("sso", 32'h3, 32'(sso));
		wr(OFF_CTRL, 32'h0);
		setf(2'b00, 1'b1);
		chk("sso", 32'h0, 32'(sso));
		setf(2'b00, 1'b0);
		chk("sso", 32'h3, 32'(sso));
		// Sleep input on pin 2, restart input on pin 0
		wr(OFF_UIO_FUNC, 32'h27);
		@(posedge clock);
		drv[2] <= 1'b1;
		cyc(4);
		chk("sso", 32'h0, 32'(sso));
		rd(OFF_STATUS);
		chk("sleep", 32'h1, 32'(rd_q[ST_SLEEP]));
		@(posedge clock);
		drv[2] <= 1'b0;
		cyc(4);
		chk("sso", 32'h3, 32'(sso));
		wr(OFF_CTRL, 32'h3);
		setf(2'b01, 1'b0);
		setf(2'b00, 1'b0);
		cyc(3);
		chk("sso", 32'h2, 32'(sso));
		press();
		chk("sso", 32'h3, 32'(sso));
		wr(OFF_CTRL, 32'h0);
		wr(OFF_UIO_FUNC, 32'h4);
		$display("Test interlock done");
		lfsr_q = lfsr(lfsr_q);
		cs = lfsr_q[7:0];
		wr(OFF_CASE, 32'(cs));
		rdchk("case", OFF_CASE, 32'(cs));
		lfsr_q = lfsr(lfsr_q);
		@(posedge clock);
		n0 <= 8'h05 + 8'(lfsr_q[2:0]);
		n1 <= 8'h05 + 8'(lfsr_q[5:3]);
		contamination <= lfsr_q[8];
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		cyc(4 * STEP);
		chk("still", 32'h0, 32'(standstill));
		chk("case", 32'(cs[7:4]), 32'(mcase));
		for (int i = 0; i < 14 * STEP && busy; i++)
			cyc(1);
		chk("encoders idle", 32'h0, 32'(busy));
		if (busy)
			finish_test();
		cyc(2 * SW + 10);
		rdchk("pos0", OFF_POS0, 32'(n0));
		rdchk("pos1", OFF_POS1, -32'(n1));
		rd(OFF_STATUS);
		chk("dir", 32'h1, 32'(rd_q[7:6]));
		chk("still", 32'h1, 32'(rd_q[5]));
		chk("case", 32'(cs[3:0]), 32'(mcase));
		$display("Test encoders done");
		for (int k = 0; k < 4; k++) begin
			wr(OFF_UIO_FUNC, 32'(k * 64 + 4));
			cyc(2);
			chk("pin3", k == 1 ? 32'(contamination) : 32'(k == 2),
				32'(uio_out[3]));
		end
		wr(OFF_UIO_FUNC, 32'h4);
		wr(OFF_CTRL, 32'h4);
		setf(2'b11, 1'b0);
		cyc(FBT + 10);
		setf(2'b00, 1'b0);
		cyc(3 * FBT);
		rd(OFF_STATUS);
		chk("fb err", 32'h0, 32'(rd_q[ST_FB_ERR]));
		@(posedge clock);
		stuck <= 1'b1;
		setf(2'b01, 1'b0);
		setf(2'b00, 1'b0);
		wait_sso(2'b00, FBT + 30);
		rd(OFF_STATUS);
		chk("fb err", 32'h1, 32'(rd_q[ST_FB_ERR]));
		@(posedge clock);
		stuck <= 1'b0;
		cyc(5);
		wr(OFF_STATUS, 32'h10);
		rd(OFF_STATUS);
		chk("fb err", 32'h0, 32'(rd_q[ST_FB_ERR]));
		$display("Test feedback done");
		wr(OFF_CTRL, 32'h18);
		cyc(2);
		chk("pair oe", 32'h3, 32'(uio_oe[1:0]));
		chk("pair out", 32'({2{sso[0]}}), 32'(uio_out[1:0]));
		chk("static oe", 32'h0, 32'(uio_oe[3:2]));
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			drv[3:2] <= 2'(k);
			cyc(4);
			rd(OFF_STATUS);
			chk("static err", 32'(k == 0 || k == 3),
				32'(rd_q[ST_STAT_ERR]));
			if (k == 1 || k == 2)
				chk("static", 32'(k == 2), 32'(rd_q[ST_STAT_VAL]));
		end
		$display("Test pins done");
		finish_test();
	end
endmodule
`default_nettype wire
